// [afeics_pkg.sv]
// Package for the input channel select block: register map, fields, types
package afeics_pkg;

	// ==========================================================
	// Register map (byte addresses on the register port)
	localparam logic [7:0] AFEICS_ADDR_MUXCFG = 8'h0c;
	localparam logic [7:0] AFEICS_ADDR_ZCFG = 8'h10;
	localparam logic [7:0] AFEICS_ADDR_STATUS = 8'h14;

	// ==========================================================
	// Field positions
	localparam int AFEICS_MUX_SEL_LO = 0;
	localparam int AFEICS_MUX_AUX_BIT = 2;
	localparam int AFEICS_MUX_SRC_BIT = 3;
	localparam int AFEICS_Z_HIGH_BIT = 0;
	localparam int AFEICS_ST_CHAN_LO = 0;
	localparam int AFEICS_ST_ZHIGH_BIT = 5;
	localparam int AFEICS_ST_TUNE_BIT = 6;
	localparam int AFEICS_ST_VALID_BIT = 7;

	// ==========================================================
	// Reset values
	localparam logic [3:0] AFEICS_MUXCFG_RST = 4'h0;
	localparam logic AFEICS_ZCFG_RST = 1'b0;
	localparam logic AFEICS_FLAG_RST = 1'b0;
	localparam logic [11:0] AFEICS_SAMPLE_RST = 12'h000;
	localparam logic [7:0] AFEICS_RDATA_ZERO = 8'h00;

	// ==========================================================
	// Widths
	localparam int AFEICS_SAMPLE_W = 12;
	localparam int AFEICS_NUM_CH = 5;

	// One-hot channel codes: A, B, C, D, auxiliary
	typedef enum logic [4:0] {
		AFEICS_CH_A = 5'h01,
		AFEICS_CH_B = 5'h02,
		AFEICS_CH_C = 5'h04,
		AFEICS_CH_D = 5'h08,
		AFEICS_CH_AUX = 5'h10
	} afeics_chan_t;

	// Channel request as presented by pins or register
	typedef struct packed {
		logic aux;
		logic [1:0] sel;
	} afeics_req_t;

	// Register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} afeics_bus_t;

endpackage

// [afeics_decode.sv]
// Channel request decoder: aux/select code to one-hot channel
`timescale 1ns/1ps
`default_nettype none
module afeics_decode
	import afeics_pkg::*;
(
	// Request in
	input wire afeics_req_t i_req,
	// One-hot channel out
	output var afeics_chan_t o_chan
);

	// ==========================================================
	// Decode
	// Aux wins over the select code
	// aux then code
	always_comb begin
		if (i_req.aux) begin
			o_chan = AFEICS_CH_AUX;
		end else begin
			case (i_req.sel)
				2'h0: o_chan = AFEICS_CH_A;
				2'h1: o_chan = AFEICS_CH_B;
				2'h2: o_chan = AFEICS_CH_C;
				2'h3: o_chan = AFEICS_CH_D;
				default: o_chan = AFEICS_CH_A;
			endcase
		end
	end

endmodule
`default_nettype wire

// [afeics_top.sv]
// Input channel select, impedance select and sample output logic
//
// Behaviour
// - Aux high picks the auxiliary channel, else codes 00..11 pick A..D.
// - Exactly one of the channels is connected to the signal chain at once.
// - After reset the select pins steer the channel until software opts in.
// - Bit 3 of register 0x0c picks register or pin channel control.
// - Low or high input impedance is chosen by register or by the pin.
// - Each result drives twelve lines, line 11 the MSB and line 0 the LSB.
// - Impedance pin high forces the high setting, low lets the register rule.
// - During filter tuning channels A to D are unusable, aux stays usable.
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
module afeics_top
	import afeics_pkg::*;
(
	// Clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_RSTN,
	// Channel select pins
	input wire logic I_AUX_SELECT,
	input wire logic [1:0] I_CHANNEL_SELECT,
	input wire logic I_IMPEDANCE_SELECT_PIN,
	// Filter tuning status
	input wire logic I_TUNE_BUSY,
	// Converter result
	input wire logic [11:0] I_CONV_DATA,
	input wire logic I_CONV_VALID,
	// Register port
	input wire logic [7:0] I_REG_ADDR,
	input wire logic [7:0] I_REG_WDATA,
	input wire logic I_REG_WR,
	input wire logic I_REG_RD,
	output logic [7:0] O_REG_RDATA,
	// Analog control
	output logic [4:0] O_CHAN_ONEHOT,
	output logic O_IMPEDANCE_HIGH,
	output logic O_CHAN_USABLE,
	// Sample output lines
	output logic [11:0] O_SAMPLE_OUT,
	output logic O_SAMPLE_VALID
);

	// ==========================================================
	// Register storage
	logic [3:0] mux_cfg;
	logic z_cfg;
	afeics_bus_t bus;
	afeics_req_t pin_req;
	afeics_req_t reg_req;
	afeics_req_t next_req;
	afeics_chan_t next_chan;
	afeics_chan_t chan;
	logic next_z;
	logic next_usable;

	// Bundle the register port
	assign bus = '{wr: I_REG_WR, rd: I_REG_RD, addr: I_REG_ADDR,
		wdata: I_REG_WDATA};

	// Channel configuration writes
	// select, aux and source bit storage
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			mux_cfg <= AFEICS_MUXCFG_RST;
		end else if (bus.wr && bus.addr == AFEICS_ADDR_MUXCFG) begin
			mux_cfg <= bus.wdata[AFEICS_MUX_SRC_BIT:AFEICS_MUX_SEL_LO];
		end
	end

	// Impedance register
	// register setting
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			z_cfg <= AFEICS_ZCFG_RST;
		end else if (bus.wr && bus.addr == AFEICS_ADDR_ZCFG) begin
			z_cfg <= bus.wdata[AFEICS_Z_HIGH_BIT];
		end
	end

	// ==========================================================
	// Channel resolution
	assign pin_req = '{aux: I_AUX_SELECT, sel: I_CHANNEL_SELECT};
	assign reg_req = '{aux: mux_cfg[AFEICS_MUX_AUX_BIT],
		sel: mux_cfg[AFEICS_MUX_AUX_BIT-1:AFEICS_MUX_SEL_LO]};

	// Pick the request source
	// source select
	always_comb begin
		if (mux_cfg[AFEICS_MUX_SRC_BIT]) begin
			next_req = reg_req;
		end else begin
			next_req = pin_req;
		end
	end

	// One decoder shared by both sources
	afeics_decode u_decode (
		.i_req(next_req),
		.o_chan(next_chan)
	);

	// Registered one-hot select, so the analog switch never sees a mix
	// of two codes mid-cycle
	// registered select
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			chan <= AFEICS_CH_A;
		end else begin
			case (next_chan)
				AFEICS_CH_A, AFEICS_CH_B, AFEICS_CH_C, AFEICS_CH_D,
				AFEICS_CH_AUX: chan <= next_chan;
				default: chan <= AFEICS_CH_A;
			endcase
		end
	end
	assign O_CHAN_ONEHOT = chan;

	// ==========================================================
	// Impedance resolution
	// pin overrides register
	assign next_z = I_IMPEDANCE_SELECT_PIN | z_cfg;

	// Registered impedance select
	// active setting
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_IMPEDANCE_HIGH <= AFEICS_ZCFG_RST;
		end else begin
			O_IMPEDANCE_HIGH <= next_z;
		end
	end

	// ==========================================================
	// Tuning guard
	// Mux channels share the tuned filter, aux bypasses it
	// tuning blocks A to D
	assign next_usable = !I_TUNE_BUSY || (next_chan == AFEICS_CH_AUX);

	// Usable flag follows the same timing as the select
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_CHAN_USABLE <= AFEICS_FLAG_RST;
		end else begin
			O_CHAN_USABLE <= next_usable;
		end
	end

	// ==========================================================
	// Sample output
	// Bits keep their order: result MSB to line 11, LSB to line 0
	// twelve lines
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_SAMPLE_OUT <= AFEICS_SAMPLE_RST;
			O_SAMPLE_VALID <= AFEICS_FLAG_RST;
		end else begin
			O_SAMPLE_VALID <= I_CONV_VALID;
			if (I_CONV_VALID) begin
				O_SAMPLE_OUT <= I_CONV_DATA[AFEICS_SAMPLE_W-1:0];
			end
		end
	end

	// ==========================================================
	// Register read port
	// Unmapped addresses read as zero; reads have no side effects
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_REG_RDATA <= AFEICS_RDATA_ZERO;
		end else if (bus.rd) begin
			case (bus.addr)
				AFEICS_ADDR_MUXCFG: O_REG_RDATA <= {4'h0, mux_cfg};
				AFEICS_ADDR_ZCFG: O_REG_RDATA <= {7'h00, z_cfg};
				AFEICS_ADDR_STATUS: O_REG_RDATA <= {O_SAMPLE_VALID,
					I_TUNE_BUSY, O_IMPEDANCE_HIGH, chan};
				default: O_REG_RDATA <= AFEICS_RDATA_ZERO;
			endcase
		end else begin
			O_REG_RDATA <= AFEICS_RDATA_ZERO;
		end
	end

endmodule
`default_nettype wire

// [afeics_asserts.sv]
// Assertion checker for the input channel select block
`timescale 1ns/1ps
`default_nettype none
module afeics_asserts
	import afeics_pkg::*;
(
	// Clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_RSTN,
	// Pins and register port
	input wire logic I_AUX_SELECT,
	input wire logic [1:0] I_CHANNEL_SELECT,
	input wire logic I_IMPEDANCE_SELECT_PIN,
	input wire logic I_TUNE_BUSY,
	input wire logic [11:0] I_CONV_DATA,
	input wire logic I_CONV_VALID,
	input wire logic [7:0] I_REG_ADDR,
	input wire logic [7:0] I_REG_WDATA,
	input wire logic I_REG_WR,
	input wire logic I_REG_RD,
	// Outputs watched
	input wire logic [7:0] O_REG_RDATA,
	input wire logic [4:0] O_CHAN_ONEHOT,
	input wire logic O_IMPEDANCE_HIGH,
	input wire logic O_CHAN_USABLE,
	input wire logic [11:0] O_SAMPLE_OUT,
	input wire logic O_SAMPLE_VALID
);
	// ==========================================================
	// Shadow of the writable fields
	logic [3:0] cfg;
	logic z;
	logic up;
	logic [2:0] r;
	logic [4:0] want;
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RSTN);
	// Shadow follows writes; up masks the first edge out of reset
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			cfg <= 4'h0;
			z <= 1'b0;
			up <= 1'b0;
		end else begin
			up <= 1'b1;
			if (I_REG_WR && I_REG_ADDR == 8'h0c) cfg <= I_REG_WDATA[3:0];
			if (I_REG_WR && I_REG_ADDR == 8'h10) z <= I_REG_WDATA[0];
		end
	end
	// Resolved request and its one-hot channel
	assign r = cfg[3] ? cfg[2:0] : {I_AUX_SELECT, I_CHANNEL_SELECT};
	assign want = r[2] ? 5'h10 : 5'h01 << r[1:0];
	// ==========================================================
	// Properties
	property p_chan;
		up |-> O_CHAN_ONEHOT == $past(want);
	endproperty
	a_chan: assert property (p_chan) else $error("channel mismatch");
	property p_one;
		$onehot(O_CHAN_ONEHOT);
	endproperty
	a_one: assert property (p_one) else $error("not one channel");
	property p_def;
		up && $past(!cfg[3] && I_AUX_SELECT) |-> O_CHAN_ONEHOT[4];
	endproperty
	a_def: assert property (p_def) else $error("pins not steering");
	property p_rd;
		I_REG_RD && I_REG_ADDR == 8'h0c |=> O_REG_RDATA[3:0] == $past(cfg);
	endproperty
	a_rd: assert property (p_rd) else $error("mux config readback");
	property p_z;
		up |-> O_IMPEDANCE_HIGH == $past(I_IMPEDANCE_SELECT_PIN | z);
	endproperty
	a_z: assert property (p_z) else $error("impedance mismatch");
	property p_zpin;
		up && $past(I_IMPEDANCE_SELECT_PIN) |-> O_IMPEDANCE_HIGH;
	endproperty
	a_zpin: assert property (p_zpin) else $error("pin not forcing");
	property p_samp;
		I_CONV_VALID |=> O_SAMPLE_VALID && O_SAMPLE_OUT == $past(I_CONV_DATA);
	endproperty
	a_samp: assert property (p_samp) else $error("sample lines wrong");
	property p_hold;
		up && !I_CONV_VALID |=> !O_SAMPLE_VALID ##0 $stable(O_SAMPLE_OUT);
	endproperty
	a_hold: assert property (p_hold) else $error("sample not held");
	property p_tune;
		up |-> O_CHAN_USABLE == (!$past(I_TUNE_BUSY) || $past(want[4]));
	endproperty
	a_tune: assert property (p_tune) else $error("usable flag wrong");
endmodule
bind afeics_top afeics_asserts u_chk(.*);
`default_nettype wire

// [afeics_host.sv]
// Host-side model: drives select pins and a converter stream
`timescale 1ns/1ps
`default_nettype none
module afeics_host
	import afeics_pkg::*;
(
	// Clock and requested code
	input wire logic i_clk,
	input wire logic [2:0] i_sel,
	// Pins and converter stream
	output var afeics_req_t o_req,
	output logic [11:0] o_data,
	output logic o_valid
);
	logic [11:0] n = 12'h000;
	// Data lines flip between samples so stale values never pass
	always @(posedge i_clk) begin
		n <= n + 12'h001;
		o_req <= i_sel;
		o_valid <= n[0];
		o_data <= n[0] ? n : ~o_data;
	end
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the input channel select block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import afeics_pkg::*;
	logic clk = 1'b0, rstn = 1'b0, zp = 1'b0, tb = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [7:0] a = 8'h00, wd = 8'h00, rdat, v;
	logic [2:0] sel = 3'h0;
	logic [11:0] cd, so, d;
	logic cv, sv, zh, us;
	logic [4:0] oh;
	afeics_req_t req;
	int bad_count = 0, compares = 0;
	always #5 clk = ~clk;
	afeics_host host(.i_clk(clk), .i_sel(sel), .o_req(req), .o_data(cd),
		.o_valid(cv));
	afeics_top dut(.I_CORE_CLK(clk), .I_RSTN(rstn), .I_AUX_SELECT(req.aux),
		.I_CHANNEL_SELECT(req.sel), .I_IMPEDANCE_SELECT_PIN(zp),
		.I_TUNE_BUSY(tb), .I_CONV_DATA(cd), .I_CONV_VALID(cv),
		.I_REG_ADDR(a), .I_REG_WDATA(wd), .I_REG_WR(wr), .I_REG_RD(rd),
		.O_REG_RDATA(rdat), .O_CHAN_ONEHOT(oh), .O_IMPEDANCE_HIGH(zh),
		.O_CHAN_USABLE(us), .O_SAMPLE_OUT(so), .O_SAMPLE_VALID(sv));
	// ==========================================================
	// Tasks
	task go(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(input logic [11:0] s, e);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %0t saw %h want %h", $time, s, e);
		end
	endtask
	task wr8(input logic [7:0] ad, x);
		@(posedge clk);
		wr <= 1'b1;
		a <= ad;
		wd <= x;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd8(input logic [7:0] ad);
		@(posedge clk);
		rd <= 1'b1;
		a <= ad;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdat;
	endtask
	function logic [4:0] ch(input logic [2:0] s);
		return s[2] ? 5'h10 : 5'h01 << s[1:0];
	endfunction
	task test_done;
		$display("mismatches %0d of %0d compares", bad_count, compares);
		if (bad_count == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ==========================================================
	// Main sequence: reset, pins, register control, impedance, tuning
	initial begin
		// Reset values only appear once the first edge has been seen
		@(posedge clk);
		#1;
		chk(oh, 5'h01);
		repeat (7) @(posedge clk);
		rstn <= 1'b1;
		rd8(8'h0c);
		chk(v, 0);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk) sel <= i[2:0];
			go(3);
			chk(oh, ch(i[2:0]));
		end
		@(posedge clk) sel <= 3'h1;
		for (int i = 0; i < 5; i++) begin
			wr8(8'h0c, {5'h01, i[2:0]});
			go(2);
			chk(oh, ch(i[2:0]));
		end
		rd8(8'h0c);
		chk(v, 8'h0c);
		// Reset in mid-run must hand the channel back to the pins
		@(posedge clk) rstn <= 1'b0;
		go(2);
		chk(oh, 5'h01);
		@(posedge clk) rstn <= 1'b1;
		go(2);
		chk(oh, 5'h02);
		wr8(8'h0c, 8'h00);
		go(2);
		chk(oh, 5'h02);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk) zp <= i[1];
			wr8(8'h10, {7'h00, i[0]});
			go(2);
			chk(zh, i[0] | i[1]);
		end
		@(posedge clk) tb <= 1'b1;
		go(2);
		chk(us, 0);
		@(posedge clk) sel <= 3'h4;
		go(3);
		chk(us, 1);
		@(posedge clk iff cv) d = cd;
		#1;
		chk(so, d);
		chk(sv, 1);
		rd8(8'h10);
		chk(v, 8'h01);
		// Status: tuning busy, high impedance, aux channel
		rd8(8'h14);
		chk(v[6:0], 7'h70);
		rd8(8'h20);
		chk(v, 0);
		test_done;
	end
	// Watchdog against a hung sequence
	initial begin
		#100000;
		bad_count++;
		test_done;
	end
endmodule
`default_nettype wire
